// File: design/dac_ctrl_map.vh
// Register offsets, field positions and reset values of the DAC control bank
`ifndef DAC_CTRL_MAP_VH
`define DAC_CTRL_MAP_VH
`define ADDR_W 4
`define DATA_W 8
`define OFS_FUNCTION 4'h5
`define OFS_SYSTEM 4'h6
`define OFS_SERIAL 4'h7
`define FN_RESET 8'h00
`define SYS_RESET 8'h00
`define SER_RESET 8'h00
`define FN_DEEMPH_LO 1
`define FN_DEEMPH_HI 0
`define FN_PHASE 2
`define FN_ZERO_MUTE 3
`define FN_MUTE_LO 4
`define FN_MUTE_HI 7
`define SYS_RATE_LO 0
`define SYS_RATE_HI 1
`define SYS_POWERDOWN_12 2
`define SYS_POWERDOWN_34 3
`define SYS_SWRST 7
`define SYS_WMASK 8'h0f
`define SER_FORMAT_LO 0
`define SER_FORMAT_HI 2
`define SER_FRAME_POL 4
`define SER_BIT_EDGE 5
`define SER_WMASK 8'h37
`define RATE_SINGLE 2'h0
`define RATE_DUAL 2'h1
`define RATE_QUAD 2'h2
`define RATE_UNUSED 2'h3
`define FORMAT_LJ24 3'h0
`define FORMAT_I2S24 3'h1
`define FORMAT_TDM0 3'h2
`define FORMAT_TDM1 3'h3
`define FORMAT_RJ24 3'h4
`define FORMAT_RJ20 3'h5
`define FORMAT_RJ18 3'h6
`define FORMAT_RJ16 3'h7
`define RST_HOLD_CYCLES 4'h4
`endif

// File: design/reset_stretch.v
// Stretches a software reset request into a fixed-length internal reset pulse
`timescale 1ns/100ps
`default_nettype none
`include "dac_ctrl_map.vh"
module reset_stretch #(
  parameter [3:0] HOLD = `RST_HOLD_CYCLES
) (
  input wire ref_clk,
  input wire rst,
  input wire start,
  output wire busy,
  output reg done_q
);
  // Remaining cycles of the reset pulse
  reg [3:0] cnt_q;
  // Busy while counting
  assign busy = (cnt_q != 4'h0);
  // Load on request, count down, flag the cycle after the final one
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 4'h1);
      if (start && !busy) begin
        cnt_q <= HOLD;
      end else if (busy) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // reset_stretch
`default_nettype wire

// File: design/dac_ctrl_regs.v
// Software-mode control register bank of a four-channel audio DAC
// Contract
// - Zero data mute defaults off, 1 enables
// - Per-channel soft mute defaults off, 1 mutes
// - System register bit layout with reserved zeros
// - Sampling mode 00 single, 01 dual, 10 quad
// - Channel 1/2 power-down defaults off, 1 powers down
// - Channel 3/4 power-down defaults off, 1 powers down
// - Software reset bit resets whole device logic; here it clears the three registers, not the read port
// - Serial port register bit layout, reserved zeros
// - Format codes for justified and I2S modes
// - Codes 010/011 select TDM, zero/one delay
// - Frame clock polarity defaults normal, 1 inverts
// - Bit clock edge defaults rising, 1 falling
// - De-emphasis only active in single rate
`timescale 1ns/100ps
`default_nettype none
`include "dac_ctrl_map.vh"
module dac_ctrl_regs (
  input wire ref_clk,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [3:0] addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data_q,
  output reg rd_valid_q,
  output wire device_reset,
  output wire zero_data_mute,
  output wire [3:0] channel_soft_mute,
  output wire output_phase_invert,
  output wire [1:0] deemphasis_select,
  output wire deemphasis_active,
  output wire powerdown_ch_1_2,
  output wire powerdown_ch_3_4,
  output wire [1:0] sampling_mode,
  output wire mode_single,
  output wire mode_dual,
  output wire mode_quad,
  output wire mode_invalid,
  output wire [2:0] data_format,
  output wire format_left_justified,
  output wire format_i2s,
  output wire format_tdm,
  output wire tdm_bit_delay,
  output wire format_right_justified,
  output wire [4:0] word_length,
  output wire frame_clock_polarity,
  output wire bit_clock_edge
);
  // Register storage
  reg [7:0] fn_q;
  reg [7:0] sys_q;
  reg [7:0] ser_q;
  // Software reset request and stretched pulse
  wire swrst_req;
  wire swrst_busy;
  wire swrst_done;
  // Combined logic reset seen by the rest of the device
  wire logic_rst;

  // Word length of a right-justified code
  function [4:0] rj_len;
    input [2:0] code;
    begin
      case (code)
        `FORMAT_RJ24: rj_len = 5'h18;
        `FORMAT_RJ20: rj_len = 5'h14;
        `FORMAT_RJ18: rj_len = 5'h12;
        `FORMAT_RJ16: rj_len = 5'h10;
        default: rj_len = 5'h18;
      endcase
    end
  endfunction

  // write of one to reset bit
  assign swrst_req = wr_en && (addr == `OFS_SYSTEM) && wr_data[`SYS_SWRST];

  // Stretch the request so every downstream block sees a clean reset
  reset_stretch u_rst (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(swrst_req),
    .busy(swrst_busy),
    .done_q(swrst_done)
  );

  assign logic_rst = rst | swrst_busy;
  assign device_reset = logic_rst;

  // Function register, cleared by either reset source
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fn_q <= `FN_RESET;
    end else if (swrst_busy) begin
      fn_q <= `FN_RESET;
    end else if (wr_en && addr == `OFS_FUNCTION) begin
      fn_q <= wr_data;
    end
  end

  // System register; only low four bits are writable
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_q <= `SYS_RESET;
    end else if (swrst_busy) begin
      sys_q <= `SYS_RESET;
    end else if (wr_en && addr == `OFS_SYSTEM && !wr_data[`SYS_SWRST]) begin
      sys_q <= wr_data & `SYS_WMASK;
    end
  end

  // Serial port register with reserved bits masked
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ser_q <= `SER_RESET;
    end else if (swrst_busy) begin
      ser_q <= `SER_RESET;
    end else if (wr_en && addr == `OFS_SERIAL) begin
      ser_q <= wr_data & `SER_WMASK;
    end
  end

  // Read port; reset bit reads one while reset is running
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        case (addr)
          `OFS_FUNCTION: rd_data_q <= fn_q;
          `OFS_SYSTEM: rd_data_q <= {swrst_busy, sys_q[6:0]};
          `OFS_SERIAL: rd_data_q <= ser_q;
          // Unmapped or outside this bank
          default: rd_data_q <= 8'h00;
        endcase
      end
    end
  end

  assign zero_data_mute = fn_q[`FN_ZERO_MUTE];
  assign channel_soft_mute = fn_q[`FN_MUTE_HI:`FN_MUTE_LO];
  assign output_phase_invert = fn_q[`FN_PHASE];
  assign deemphasis_select = fn_q[`FN_DEEMPH_LO:`FN_DEEMPH_HI];
  assign powerdown_ch_1_2 = sys_q[`SYS_POWERDOWN_12];
  assign powerdown_ch_3_4 = sys_q[`SYS_POWERDOWN_34];
  assign sampling_mode = sys_q[`SYS_RATE_HI:`SYS_RATE_LO];
  assign mode_single = (sampling_mode == `RATE_SINGLE);
  assign mode_dual = (sampling_mode == `RATE_DUAL);
  assign mode_quad = (sampling_mode == `RATE_QUAD);
  assign mode_invalid = (sampling_mode == `RATE_UNUSED);
  assign deemphasis_active = mode_single && (deemphasis_select != 2'h0);
  assign data_format = ser_q[`SER_FORMAT_HI:`SER_FORMAT_LO];
  assign format_left_justified = (data_format == `FORMAT_LJ24);
  assign format_i2s = (data_format == `FORMAT_I2S24);
  assign format_right_justified = data_format[2];
  // Non right-justified formats all carry 24-bit words
  assign word_length = format_right_justified ? rj_len(data_format) : 5'h18;
  assign format_tdm = (data_format == `FORMAT_TDM0) || (data_format == `FORMAT_TDM1);
  assign tdm_bit_delay = (data_format == `FORMAT_TDM1);
  assign frame_clock_polarity = ser_q[`SER_FRAME_POL];
  assign bit_clock_edge = ser_q[`SER_BIT_EDGE];
endmodule // dac_ctrl_regs
`default_nettype wire

// File: verification/dac_ctrl_checker.sv
// Port-level assertions for the DAC control bank
`timescale 1ns/100ps
`default_nettype none
module dac_ctrl_checker (
  input wire ref_clk,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [3:0] addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data_q,
  input wire rd_valid_q,
  input wire device_reset,
  input wire zero_data_mute,
  input wire [3:0] channel_soft_mute,
  input wire deemphasis_active,
  input wire powerdown_ch_1_2,
  input wire powerdown_ch_3_4,
  input wire [1:0] sampling_mode,
  input wire [2:0] data_format,
  input wire frame_clock_polarity,
  input wire bit_clock_edge
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_fn_write: assert property (wr_en && addr == 4'h5 && !device_reset
    |=> {channel_soft_mute, zero_data_mute, 3'h0} == ($past(wr_data) & 8'hf8)) else $error("fn");
  a_sys_write: assert property (wr_en && addr == 4'h6 && !device_reset && !wr_data[7]
    |=> {4'h0, powerdown_ch_3_4, powerdown_ch_1_2, sampling_mode} == ($past(wr_data) & 8'h0f))
    else $error("sys");
  a_ser_write: assert property (wr_en && addr == 4'h7 && !device_reset
    |=> {2'h0, bit_clock_edge, frame_clock_polarity, 1'b0, data_format} == ($past(wr_data) & 8'h37))
    else $error("ser");
  a_sys_reserved: assert property (rd_valid_q && $past(addr) == 4'h6
    |-> rd_data_q[6:4] == 3'h0) else $error("sys rsv");
  a_ser_reserved: assert property (rd_valid_q && $past(addr) == 4'h7
    |-> rd_data_q[7:6] == 2'h0 && !rd_data_q[3]) else $error("ser rsv");
  a_deemph_single: assert property (deemphasis_active |-> sampling_mode == 2'h0)
    else $error("deemph");
  a_swrst_len: assert property (wr_en && addr == 4'h6 && wr_data[7] && !device_reset
    |=> device_reset [*4] ##[1:2] !device_reset) else $error("swrst");
  a_swrst_clear: assert property ($fell(device_reset)
    |-> !zero_data_mute && data_format == 3'h0 && sampling_mode == 2'h0) else $error("clr");
endmodule // dac_ctrl_checker
`default_nettype wire

// File: verification/host_model.sv
// Host side of the register strobe port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire ref_clk,
  output logic wr_en,
  output logic rd_en,
  output logic [3:0] addr,
  output logic [7:0] wr_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 8'h00;
  end
  // keyed requests only, launched from the system clock
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    // Released lines show junk, not the old value
    addr <= ~a;
    wr_data <= ~d;
  endtask
endmodule // host_model
`default_nettype wire

// File: verification/dac_ctrl_regs_tb.sv
// Self-checking bench for the DAC control bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module dac_ctrl_regs_tb;
  logic ref_clk, rst;
  wire wr_en, rd_en, rd_valid_q, device_reset, zero_data_mute, output_phase_invert;
  wire deemphasis_active, powerdown_ch_1_2, powerdown_ch_3_4, mode_single, mode_dual;
  wire mode_quad, mode_invalid, format_left_justified, format_i2s, format_tdm, tdm_bit_delay;
  wire format_right_justified, frame_clock_polarity, bit_clock_edge;
  wire [1:0] deemphasis_select, sampling_mode;
  wire [2:0] data_format;
  wire [3:0] addr, channel_soft_mute;
  wire [4:0] word_length;
  wire [7:0] wr_data, rd_data_q;
  int n_fail, checks_done;
  logic [7:0] d, fn;
  logic [1:0] rate;
  dac_ctrl_regs dac_ctrl_regs_inst (.*);
  host_model host_model_inst (.*);
  // Expected word length per format code
  function automatic logic [4:0] wl(input logic [2:0] f);
    case (f)
      3'h5: wl = 5'h14;
      3'h6: wl = 5'h12;
      3'h7: wl = 5'h10;
      default: wl = 5'h18;
    endcase
  endfunction
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    host_model_inst.xfer(1'b0, a, 8'h00);
    #1;
    `CHK("rd_valid", 1'b1, rd_valid_q)
    `CHK("rd_data", e, rd_data_q)
  endtask
  task wrap_up;
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    n_fail = 0;
    checks_done = 0;
    fn = 8'h00;
    rst = 1'b1;
    void'($urandom(71));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 5; a < 8; a++) rchk(a[3:0], 8'h00);
    for (int i = 0; i < 24; i++) begin
      fn = $urandom;
      host_model_inst.xfer(1'b1, 4'h5, fn);
      rchk(4'h5, fn);
      `CHK("fn_out", fn, {channel_soft_mute, zero_data_mute, output_phase_invert, deemphasis_select})
      d = $urandom;
      // Code 11 is never sent
      rate = 2'(i % 3);
      host_model_inst.xfer(1'b1, 4'h6, {1'b0, d[6:2], rate});
      rchk(4'h6, {4'h0, d[3:2], rate});
      `CHK("deemph", rate == 2'h0 && fn[1:0] != 2'h0, deemphasis_active)
      `CHK("quad", rate == 2'h2, mode_quad)
      `CHK("modes", {rate == 2'h0, rate == 2'h1, 1'b0}, {mode_single, mode_dual, mode_invalid})
      `CHK("pdn", d[3:2], {powerdown_ch_3_4, powerdown_ch_1_2})
      d = $urandom;
      host_model_inst.xfer(1'b1, 4'h7, {d[7:3], i[2:0]});
      rchk(4'h7, {2'h0, d[5:4], 1'b0, i[2:0]});
      `CHK("format", {i[2:1] == 2'h1, i[2:0] == 3'h3, wl(i[2:0])}, {format_tdm, format_tdm & tdm_bit_delay, word_length})
      `CHK("clk_cfg", d[5:4], {bit_clock_edge, frame_clock_polarity})
      `CHK("just", {i[2:0] == 3'h0, i[2:0] == 3'h1, i[2]}, {format_left_justified, format_i2s, format_right_justified})
    end
    host_model_inst.xfer(1'b1, 4'h9, 8'hff);
    rchk(4'h9, 8'h00);
    host_model_inst.xfer(1'b1, 4'h6, 8'h80);
    #1;
    `CHK("swrst", 1'b1, device_reset)
    for (int k = 0; k < 20 && device_reset; k++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("swrst_end", 1'b0, device_reset)
    for (int a = 5; a < 8; a++) rchk(a[3:0], 8'h00);
    wrap_up;
  end
endmodule // dac_ctrl_regs_tb
bind dac_ctrl_regs dac_ctrl_checker dac_ctrl_checker_inst (.*);
`default_nettype wire
